// ==== dv/cteic_inline_cfg_test.sv ====
// Testbench: register access, S0 matching and spacing selection of the in-line CTE block
`timescale 1ns/1ps
`default_nettype none

module cteic_inline_cfg_test;
    import cteic_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} cteic_exp_type;
    logic              core_clk = 1'b0;
    logic              srst = 1'b1;
    logic [7:0]        awaddr = '0, araddr = '0, s0_data = '0;
    logic [31:0]       wdata = '0, rdata;
    logic [3:0]        wstrb = '0;
    logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic              two_us_cmd = 1'b0, switching_cmd = 1'b0, s0_go = 1'b0;
    cteic_rx_type      rx;
    cteic_spacing_type spacing;
    cteic_exp_type     rq[$], re;
    logic [1:0]        wq[$];
    int                errors = 0, n_checks = 0, cycles = 0, tick_gap = -1;
    logic [5:0]        exp_eighths = '0;
    logic [31:0]       seed = 32'hAFEB;

    always #12.5 core_clk = ~core_clk;

    cteic_inline_cfg cteic_inline_cfg_inst (
        .core_clk(core_clk), .srst(srst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rx(rx), .spacing(spacing)
    );

    cteic_rx_model cteic_rx_model_inst (
        .core_clk(core_clk), .srst(srst), .two_us_cmd(two_us_cmd), .switching_cmd(switching_cmd),
        .s0_go(s0_go), .s0_data(s0_data), .rx(rx)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // Write with both channels offered together, expected response queued
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        wq.push_back(r);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        do @(posedge core_clk); while (!bvalid);
        bready <= 1'b0;
        @(posedge core_clk);
    endtask : axi_wr

    // Read with expected data, compare mask and response queued
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
        rq.push_back('{d, m, r});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge core_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge core_clk); while (!rvalid);
        rready <= 1'b0;
        @(posedge core_clk);
    endtask : axi_rd

    task automatic send_s0(input logic [7:0] b);
        s0_data <= b;
        s0_go <= 1'b1;
        @(posedge core_clk);
        s0_go <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : send_s0

    // ------------------------------------------------------------------
    // Monitors
    // ------------------------------------------------------------------
    // Bus answers are matched against the oldest queued note
    always @(posedge core_clk) begin
        if (rvalid && rready) begin
            re = rq.pop_front();
            check("rdata", rdata & re.m, re.d & re.m);
            check("rresp", 32'(rresp), 32'(re.r));
        end
        if (bvalid && bready) check("bresp", 32'(bresp), 32'(wq.pop_front()));
    end

    // Each sample tick carries the spacing and arrives one spacing after the last
    always @(posedge core_clk) begin
        if (!spacing.active) begin
            tick_gap <= -1;
        end else if (spacing.sample_tick) begin
            if (tick_gap >= 0) check("tick gap", 32'(tick_gap + 1), 32'(exp_eighths) * 5);
            check("eighths", 32'(spacing.eighths), 32'(exp_eighths));
            tick_gap <= 0;
        end else if (tick_gap >= 0) begin
            tick_gap <= tick_gap + 1;
        end
    end

    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        logic [7:0]  p, m, b, sel;
        logic [1:0]  swi;
        logic        aod, act;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        // Reset values, byte strobes, read-only status and an unmapped place
        axi_rd(CTEIC_CTRL_OFS, 32'h20, '1, CTEIC_RESP_OKAY);
        axi_rd(CTEIC_SPACING_OFS, 32'h11, '1, CTEIC_RESP_OKAY);
        axi_rd(CTEIC_S0_OFS, 32'h0, '1, CTEIC_RESP_OKAY);
        axi_rd(CTEIC_STATUS_OFS, 32'h0, 32'h70, CTEIC_RESP_OKAY);
        axi_rd(8'h10, 32'h0, '1, CTEIC_RESP_SLVERR);
        axi_wr(CTEIC_S0_OFS, 32'hA55A, 4'hF, CTEIC_RESP_OKAY);
        axi_wr(CTEIC_S0_OFS, 32'h3CFF, 4'h2, CTEIC_RESP_OKAY);
        axi_wr(CTEIC_STATUS_OFS, 32'hFF, 4'hF, CTEIC_RESP_OKAY);
        axi_wr(8'h10, 32'hFFFF, 4'hF, CTEIC_RESP_SLVERR);
        axi_rd(CTEIC_S0_OFS, 32'h3C5A, '1, CTEIC_RESP_OKAY);
        axi_rd(CTEIC_STATUS_OFS, 32'h0, 32'h60, CTEIC_RESP_OKAY);
        $display("test registers finished");
        // Masked compare of random headers
        for (int i = 0; i < 10; i++) begin
            p = 8'(xs());
            m = (i == 0) ? 8'h01 : 8'(xs());
            b = 8'(xs());
            axi_wr(CTEIC_S0_OFS, {16'h0, m, p}, 4'hF, CTEIC_RESP_OKAY);
            send_s0(b);
            axi_rd(CTEIC_STATUS_OFS, {25'h0, 1'b1, ((b ^ p) & m) == 8'h0, 5'h0}, 32'h60, CTEIC_RESP_OKAY);
        end
        $display("test s0 match finished");
        // Each gating condition missing in turn keeps the spacing off
        axi_wr(CTEIC_SPACING_OFS, 32'h33, 4'hF, CTEIC_RESP_OKAY);
        axi_wr(CTEIC_S0_OFS, 32'h0101, 4'hF, CTEIC_RESP_OKAY);
        send_s0(8'h00);
        switching_cmd <= 1'b1;
        axi_wr(CTEIC_CTRL_OFS, 32'h21, 4'hF, CTEIC_RESP_OKAY);
        axi_rd(CTEIC_STATUS_OFS, 32'h0, 32'h30, CTEIC_RESP_OKAY);
        // The match opens the gate briefly with the one-us setting 3, i.e. 1 us
        exp_eighths <= 6'h08;
        send_s0(8'h01);
        axi_wr(CTEIC_CTRL_OFS, 32'h20, 4'hF, CTEIC_RESP_OKAY);
        axi_rd(CTEIC_STATUS_OFS, 32'h20, 32'h30, CTEIC_RESP_OKAY);
        switching_cmd <= 1'b0;
        axi_wr(CTEIC_CTRL_OFS, 32'h21, 4'hF, CTEIC_RESP_OKAY);
        axi_rd(CTEIC_STATUS_OFS, 32'h20, 32'h30, CTEIC_RESP_OKAY);
        $display("test gating finished");
        // Two-us selectors 0..6 and one-us selectors 1..7 under both angle modes, the 4us and 2us intervals and unused interval 3
        for (int md = 0; md < 5; md++) begin
            for (int c = 1; c <= 7; c++) begin
                aod = (md < 2);
                swi = (md == 2) ? CTEIC_SWI_4US : (md == 4) ? 2'h3 : CTEIC_SWI_2US;
                sel = (md == 0 || md == 2) ? 8'(7 - c) : (md == 4) ? 8'h0 : 8'(c);
                act = (sel >= 1 && sel <= 6);
                exp_eighths <= act ? 6'd32 >> (sel - 1) : 6'd0;
                axi_wr(CTEIC_SPACING_OFS, 32'((7 - c) << 4 | c), 4'hF, CTEIC_RESP_OKAY);
                axi_wr(CTEIC_CTRL_OFS, {26'h0, swi, 2'b00, aod, 1'b1}, 4'hF, CTEIC_RESP_OKAY);
                two_us_cmd <= (md == 0);
                switching_cmd <= 1'b1;
                // Long enough for at least two ticks at the selected spacing
                repeat (act ? (32'h20 >> (sel - 1)) * 10 + 4 : 4) @(posedge core_clk);
                axi_rd(CTEIC_STATUS_OFS, {27'h0, act, 1'b0, sel[2:0]}, (md == 4 || act) ? 32'h17 : 32'h10,
                       CTEIC_RESP_OKAY);
                switching_cmd <= 1'b0;
                repeat (4) @(posedge core_clk);
            end
        end
        $display("test spacing select finished");
        summarize();
    end
endmodule : cteic_inline_cfg_test

`default_nettype wire

// ==== dv/cteic_rx_model.sv ====
// Partner model: receive parser feeding CTE type, switching window and S0 header bits
`timescale 1ns/1ps
`default_nettype none

module cteic_rx_model
    import cteic_pkg::*;
(
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    // Commands from the bench
    input  wire logic                    two_us_cmd,
    input  wire logic                    switching_cmd,
    input  wire logic                    s0_go,
    input  wire logic [7:0]              s0_data,
    // Parsed header towards the block
    output var  cteic_pkg::cteic_rx_type rx
);
    // ------------------------------------------------------------------
    // Parser outputs
    // ------------------------------------------------------------------
    // Levels follow the commands; S0 bits are only meaningful with their strobe
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rx <= '0;
        end else begin
            rx.cte_two_us   <= two_us_cmd;
            rx.in_switching <= switching_cmd;
            rx.s0_valid     <= s0_go;
            rx.s0_bits      <= s0_go ? s0_data : ~rx.s0_bits;
        end
    end
endmodule : cteic_rx_model

`default_nettype wire

// ==== hw/cteic_inline_cfg.sv ====
// Module: in-line CTE sample spacing selection and S0 header gating with an AXI4-Lite register slave
//
// Notes on behaviour
// R1 - Selector 1..6 means 4us down to 0.125us
// R2 - Spacing only during switching, in-line mode enabled
// R3 - Departure angle, two-us type uses two-us setting
// R4 - Arrival angle, 4us interval uses two-us setting
// R5 - Arrival angle, 2us interval uses one-us setting
// R6 - Software-writable S0 reference pattern
// R7 - Software-writable S0 compare mask
// R8 - Bit zero is first received S0 bit
// R9 - Match when all unmasked bits equal reference
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module cteic_inline_cfg
    import cteic_pkg::*;
(
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    // AXI4-Lite write channels
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output var  logic                    s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output var  logic                    s_axi_wready,
    output var  logic [1:0]              s_axi_bresp,
    output var  logic                    s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output var  logic                    s_axi_arready,
    output var  logic [31:0]             s_axi_rdata,
    output var  logic [1:0]              s_axi_rresp,
    output var  logic                    s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // Receive path
    input  wire cteic_pkg::cteic_rx_type rx,
    // Sampling control
    output var  cteic_pkg::cteic_spacing_type spacing
);
    import cteic_pkg::*;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Selector to spacing in 0.125 us units, zero for unused codes
    function automatic logic [5:0] spc_eighths(input logic [2:0] code);
        logic [5:0] r;
        r = 6'h00;
        unique case (code)
            3'h1:    r = 6'h20;
            3'h2:    r = 6'h10;
            3'h3:    r = 6'h08;
            3'h4:    r = 6'h04;
            3'h5:    r = 6'h02;
            3'h6:    r = 6'h01;
            default: r = 6'h00;
        endcase
        return r;
    endfunction : spc_eighths

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Address decode shared by the write and read paths
    function automatic logic mapped(input logic [7:0] a);
        return (a == CTEIC_CTRL_OFS) || (a == CTEIC_SPACING_OFS) || (a == CTEIC_S0_OFS) || (a == CTEIC_STATUS_OFS);
    endfunction : mapped

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [31:0]       ctrl_q,    ctrl_d;
    logic [31:0]       spc_q,     spc_d;
    logic [31:0]       s0reg_q,   s0reg_d;
    logic              aw_full_q, aw_full_d;
    logic              w_full_q,  w_full_d;
    logic [7:0]        awaddr_q,  awaddr_d;
    logic [31:0]       wdata_q,   wdata_d;
    logic [3:0]        wstrb_q,   wstrb_d;
    logic              awready_q, awready_d;
    logic              wready_q,  wready_d;
    logic              bvalid_q,  bvalid_d;
    logic [1:0]        bresp_q,   bresp_d;
    logic              arready_q, arready_d;
    logic              rvalid_q,  rvalid_d;
    logic [31:0]       rdata_q,   rdata_d;
    logic [1:0]        rresp_q,   rresp_d;
    logic              match_q,   match_d;
    logic              seen_q,    seen_d;
    logic [CTEIC_TICK_W-1:0] tick_cnt_q, tick_cnt_d;
    cteic_spacing_type spacing_q, spacing_d;
    logic              wr_fire;
    logic              en, aod;
    logic [1:0]        swi;
    logic [2:0]        one_us_sel, two_us_sel;
    logic [CTEIC_S0_W-1:0] pattern, mask;
    logic [31:0]       status_word;

    assign en         = ctrl_q[CTEIC_CTRL_EN_POS];
    assign aod        = ctrl_q[CTEIC_CTRL_AOD_POS];
    assign swi        = ctrl_q[CTEIC_CTRL_SWI_POS +: 2];
    assign one_us_sel = spc_q[CTEIC_SPC_ONE_POS +: 3];
    assign two_us_sel = spc_q[CTEIC_SPC_TWO_POS +: 3];
    assign pattern    = s0reg_q[CTEIC_S0_PAT_POS +: CTEIC_S0_W];  // R6
    assign mask       = s0reg_q[CTEIC_S0_MASK_POS +: CTEIC_S0_W]; // R7
    assign wr_fire    = aw_full_q && w_full_q && !bvalid_q;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[CTEIC_ST_CODE_POS +: 3] = spacing_q.code;
        status_word[CTEIC_ST_ACTIVE_POS]    = spacing_q.active;
        status_word[CTEIC_ST_MATCH_POS]     = match_q;
        status_word[CTEIC_ST_SEEN_POS]      = seen_q;
    end

    // ------------------------------------------------------------------
    // Bus slave and register file
    // ------------------------------------------------------------------
    // Address and data are latched in either order; one write answered when both are held
    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d  = w_full_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        ctrl_d    = ctrl_q;
        spc_d     = spc_q;
        s0reg_d   = s0reg_q;
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (s_axi_awvalid && awready_q) begin
            aw_full_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_full_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = mapped(awaddr_q) ? CTEIC_RESP_OKAY : CTEIC_RESP_SLVERR;
            unique case (awaddr_q)
                CTEIC_CTRL_OFS:    ctrl_d  = merge(ctrl_q, wdata_q, wstrb_q);
                CTEIC_SPACING_OFS: spc_d   = merge(spc_q, wdata_q, wstrb_q);
                CTEIC_S0_OFS:      s0reg_d = merge(s0reg_q, wdata_q, wstrb_q); // R6 R7
                default:           ;
            endcase
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // Reads answer one cycle after the address is taken
        arready_d = 1'b0;
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = mapped(s_axi_araddr) ? CTEIC_RESP_OKAY : CTEIC_RESP_SLVERR;
            unique case (s_axi_araddr)
                CTEIC_CTRL_OFS:    rdata_d = ctrl_q;
                CTEIC_SPACING_OFS: rdata_d = spc_q;
                CTEIC_S0_OFS:      rdata_d = s0reg_q;
                CTEIC_STATUS_OFS:  rdata_d = status_word;
                default:           rdata_d = 32'h0000_0000;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end else if (!rvalid_q && !arready_q) begin
            arready_d = 1'b1;
        end
        awready_d = !aw_full_d && !bvalid_d;
        wready_d  = !w_full_d && !bvalid_d;
        // Unused bits of the stored words stay zero
        ctrl_d  = ctrl_d & 32'h0000_0033;
        spc_d   = spc_d & 32'h0000_0077;
        s0reg_d = s0reg_d & 32'h0000_FFFF;
    end

    // ------------------------------------------------------------------
    // Spacing selection, S0 match and sample timing
    // ------------------------------------------------------------------
    always_comb begin
        match_d = match_q;
        seen_d  = seen_q;
        if (rx.s0_valid) begin
            // Bit 0 of pattern, mask and received field is the earliest bit
            match_d = ((rx.s0_bits ^ pattern) & mask) == '0; // R8 R9
            seen_d  = 1'b1;
        end
        spacing_d        = '0;
        spacing_d.active = en && rx.in_switching && match_q; // R2
        if (aod) begin
            spacing_d.code = rx.cte_two_us ? two_us_sel : one_us_sel; // R3
        end else if (swi == CTEIC_SWI_4US) begin
            spacing_d.code = two_us_sel; // R4
        end else if (swi == CTEIC_SWI_2US) begin
            spacing_d.code = one_us_sel; // R5
        end else begin
            spacing_d.active = 1'b0;
        end
        spacing_d.eighths = spc_eighths(spacing_d.code); // R1
        if (spacing_d.eighths == 6'h00) begin
            spacing_d.active = 1'b0;
        end
        // Tick on entry and every spacing interval while active
        tick_cnt_d = '0;
        if (spacing_d.active) begin
            if (!spacing_q.active || tick_cnt_q <= 8'h01) begin
                spacing_d.sample_tick = 1'b1;
                tick_cnt_d = 8'(spacing_d.eighths * CTEIC_EIGHTH_CYC);
            end else begin
                tick_cnt_d = tick_cnt_q - 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl_q     <= {26'h0, CTEIC_SWI_RST, 2'h0, CTEIC_AOD_RST, CTEIC_EN_RST};
            spc_q      <= {25'h0, CTEIC_TWO_RST, 1'b0, CTEIC_ONE_RST};
            s0reg_q    <= {16'h0, CTEIC_MASK_RST, CTEIC_PAT_RST};
            aw_full_q  <= 1'b0;
            w_full_q   <= 1'b0;
            awaddr_q   <= 8'h00;
            wdata_q    <= 32'h0000_0000;
            wstrb_q    <= 4'h0;
            awready_q  <= 1'b0;
            wready_q   <= 1'b0;
            bvalid_q   <= 1'b0;
            bresp_q    <= 2'h0;
            arready_q  <= 1'b0;
            rvalid_q   <= 1'b0;
            rdata_q    <= 32'h0000_0000;
            rresp_q    <= 2'h0;
            match_q    <= 1'b0;
            seen_q     <= 1'b0;
            tick_cnt_q <= '0;
            spacing_q  <= '0;
        end else begin
            ctrl_q     <= ctrl_d;
            spc_q      <= spc_d;
            s0reg_q    <= s0reg_d;
            aw_full_q  <= aw_full_d;
            w_full_q   <= w_full_d;
            awaddr_q   <= awaddr_d;
            wdata_q    <= wdata_d;
            wstrb_q    <= wstrb_d;
            awready_q  <= awready_d;
            wready_q   <= wready_d;
            bvalid_q   <= bvalid_d;
            bresp_q    <= bresp_d;
            arready_q  <= arready_d;
            rvalid_q   <= rvalid_d;
            rdata_q    <= rdata_d;
            rresp_q    <= rresp_d;
            match_q    <= match_d;
            seen_q     <= seen_d;
            tick_cnt_q <= tick_cnt_d;
            spacing_q  <= spacing_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign spacing       = spacing_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_aod_two;
        aod && rx.cte_two_us;
    endsequence

    a_spacing_decode: assert property (spacing_q.active |-> spacing_q.eighths == spc_eighths(spacing_q.code)
                                       && spacing_q.eighths != 6'h00) // R1
        else $error("applied spacing does not match selector");
    a_switch_gate: assert property (!rx.in_switching || !en |=> !spacing_q.active) // R2
        else $error("spacing active outside switching or with mode off");
    a_aod_two_us: assert property (s_aod_two |=> spacing_q.code == $past(two_us_sel)) // R3
        else $error("two-us departure type did not select two-us setting");
    a_aoa_four_us: assert property (!aod && swi == CTEIC_SWI_4US |=> spacing_q.code == $past(two_us_sel)) // R4
        else $error("4us interval did not select two-us setting");
    a_aoa_two_us: assert property (!aod && swi == CTEIC_SWI_2US |=> spacing_q.code == $past(one_us_sel)) // R5
        else $error("2us interval did not select one-us setting");
    a_pattern_write: assert property (wr_fire && awaddr_q == CTEIC_S0_OFS && wstrb_q[0]
                                      |=> pattern == $past(wdata_q[7:0])) // R6
        else $error("pattern write not stored");
    a_mask_write: assert property (wr_fire && awaddr_q == CTEIC_S0_OFS && wstrb_q[1]
                                   |=> mask == $past(wdata_q[15:8])) // R7
        else $error("mask write not stored");
    a_s0_compare: assert property (rx.s0_valid |=> match_q == ((($past(rx.s0_bits) ^ $past(pattern))
                                   & $past(mask)) == '0)) // R8 R9
        else $error("S0 match result wrong");
    a_match_gate: assert property (!match_q |=> !spacing_q.active) // R9
        else $error("spacing active without S0 match");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");

endmodule : cteic_inline_cfg

`default_nettype wire

// ==== hw/cteic_pkg.sv ====
// Package: register map, field layout, reset values and carrier types of the in-line CTE sample configuration
package cteic_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] CTEIC_CTRL_OFS    = 8'h00;
    localparam logic [7:0] CTEIC_SPACING_OFS = 8'h04;
    localparam logic [7:0] CTEIC_S0_OFS      = 8'h08;
    localparam logic [7:0] CTEIC_STATUS_OFS  = 8'h0C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTEIC_CTRL_EN_POS    = 0;  // inline_cte_config_enable
    localparam int CTEIC_CTRL_AOD_POS   = 1;  // 1 = departure angle, 0 = arrival angle
    localparam int CTEIC_CTRL_SWI_POS   = 4;  // antenna_switch_interval, 2 bits
    localparam int CTEIC_SPC_ONE_POS    = 0;  // inline_rx_spacing_one_us_mode, 3 bits
    localparam int CTEIC_SPC_TWO_POS    = 4;  // inline_rx_spacing_two_us_mode, 3 bits
    localparam int CTEIC_S0_PAT_POS     = 0;  // header_first_field_pattern
    localparam int CTEIC_S0_MASK_POS    = 8;  // header_first_field_mask
    localparam int CTEIC_ST_CODE_POS    = 0;  // applied spacing code, 3 bits
    localparam int CTEIC_ST_ACTIVE_POS  = 4;
    localparam int CTEIC_ST_MATCH_POS   = 5;
    localparam int CTEIC_ST_SEEN_POS    = 6;
    localparam int CTEIC_S0_W           = 8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic       CTEIC_EN_RST   = 1'b0;
    localparam logic       CTEIC_AOD_RST  = 1'b0;
    localparam logic [1:0] CTEIC_SWI_RST  = 2'h2;
    localparam logic [2:0] CTEIC_ONE_RST  = 3'h1;
    localparam logic [2:0] CTEIC_TWO_RST  = 3'h1;
    localparam logic [7:0] CTEIC_PAT_RST  = 8'h00;
    localparam logic [7:0] CTEIC_MASK_RST = 8'h00;

    // ------------------------------------------------------------------
    // Encodings and timing
    // ------------------------------------------------------------------
    localparam logic [1:0] CTEIC_SWI_4US = 2'h1;
    localparam logic [1:0] CTEIC_SWI_2US = 2'h2;
    localparam logic [1:0] CTEIC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CTEIC_RESP_SLVERR = 2'h2;
    localparam int CTEIC_CLK_MHZ       = 40;
    localparam int CTEIC_EIGHTH_NS     = 125;  // spacing unit, 0.125 us
    localparam int CTEIC_EIGHTH_CYC    = (CTEIC_EIGHTH_NS * CTEIC_CLK_MHZ + 999) / 1000;
    localparam int CTEIC_TICK_W        = 8;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                  cte_two_us;   // parsed CTE type is two-microsecond departure
        logic                  in_switching; // antenna-switching period in progress
        logic                  s0_valid;     // one-cycle strobe with s0_bits
        logic [CTEIC_S0_W-1:0] s0_bits;      // bit 0 is first received
    } cteic_rx_type;

    typedef struct packed {
        logic       active;      // in-line spacing applied now
        logic [2:0] code;        // applied selector
        logic [5:0] eighths;     // spacing in 0.125 us units
        logic       sample_tick; // one-cycle strobe per sample
    } cteic_spacing_type;

endpackage : cteic_pkg
